// ---- src/sxc_top.sv ----
// Contract
// - Serialize an 8/10/16/20-bit word, least significant bit first.
// - Force-idle puts transmitter in electrical idle only in PIPE mode.
// - Receiver detection runs only while transmitter is idle.
// - Unused receive channel powers down its PLL and recovery unit.
// - Data lock wins; else reference lock; else automatic switchover.
// - With no override asserted, lock mode is automatic.
// - Auto mode moves to data lock only within the ppm threshold.
// - Data-lock indicator high while locked to data.
// - Reference-lock indicator reports PLL lock to reference clock.
module sxc_top
    import sxc_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire sxc_pkg::sxc_apb_req_t APB_REQ,
    output logic                      PREADY,
    output logic [31:0]               PRDATA,
    output logic                      PSLVERR,
    input  wire sxc_pkg::sxc_pll_stat_t PLL_STAT,
    input  wire logic                 RX_DETECT_REQ,
    output logic                      TX_SERIAL,
    output logic                      TX_IDLE,
    output logic                      RX_DETECT_EN,
    output logic                      RX_PWRDN,
    output logic                      DATA_LOCKED,
    output logic                      REF_LOCKED,
    output logic                      IRQ
);
    import sxc_pkg::*;

    logic [31:0]    ctrl_ff;
    logic [15:0]    ppm_thr_ff;
    logic [19:0]    hold_ff;
    logic           hold_vld_ff;
    logic [19:0]    shift_ff;
    logic [4:0]     bit_cnt_ff;
    logic           active_ff;
    logic [EV_N-1:0] irq_stat_ff;
    logic [EV_N-1:0] irq_mask_ff;
    sxc_cru_state_t cru_ff;

    logic           wr_acc;
    logic           rd_acc;
    logic           last_bit;
    logic           load_word;
    logic           pipe_idle;
    sxc_width_t     width;
    sxc_lock_mode_t lock_mode;
    logic [EV_N-1:0] ev;
    sxc_cru_state_t nxt_cru;

    assign wr_acc = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
    assign rd_acc = APB_REQ.psel & ~APB_REQ.pwrite;
    assign width  = sxc_width_t'(ctrl_ff[CTRL_WIDTH_LO +: 2]);

    // Single-cycle answer; access phase always ready
    always_ff @(posedge CLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= APB_REQ.psel & ~APB_REQ.penable;
            PSLVERR <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_ff    <= CTRL_RESET;
            ppm_thr_ff <= PPM_RESET;
        end else if (wr_acc && PREADY) begin
            if (APB_REQ.paddr == OFS_CTRL) begin
                ctrl_ff <= APB_REQ.pwdata;
            end
            if (APB_REQ.paddr == OFS_PPM_CFG) begin
                ppm_thr_ff <= APB_REQ.pwdata[15:0];
            end
        end
    end

    // Read data prepared in setup, valid during access
    always_ff @(posedge CLK) begin
        if (RST) begin
            PRDATA <= UNMAPPED_DATA;
        end else if (rd_acc && !APB_REQ.penable) begin
            case (APB_REQ.paddr)
                OFS_CTRL:     PRDATA <= ctrl_ff;
                OFS_STATUS:   PRDATA <= {25'h0, hold_vld_ff, active_ff, TX_IDLE,
                                         RX_PWRDN, cru_ff, REF_LOCKED};
                OFS_TXWORD:   PRDATA <= {12'h000, hold_ff};
                OFS_IRQ_STAT: PRDATA <= {28'h0, irq_stat_ff};
                OFS_IRQ_MASK: PRDATA <= {28'h0, irq_mask_ff};
                OFS_PPM_CFG:  PRDATA <= {16'h0000, ppm_thr_ff};
                default:      PRDATA <= UNMAPPED_DATA;
            endcase
        end
    end

    // Holding register; a full one takes no new write
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_ff     <= 20'h00000;
            hold_vld_ff <= 1'b0;
        end else if (wr_acc && PREADY && APB_REQ.paddr == OFS_TXWORD && !hold_vld_ff) begin
            hold_ff     <= APB_REQ.pwdata[19:0];
            hold_vld_ff <= 1'b1;
        end else if (load_word) begin
            hold_vld_ff <= 1'b0;
        end
    end

    assign last_bit  = active_ff && (bit_cnt_ff == width_bits(width) - ONE5);
    assign load_word = hold_vld_ff && (!active_ff || last_bit);

    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_ff   <= 20'h00000;
            bit_cnt_ff <= ZERO5;
            active_ff  <= 1'b0;
            TX_SERIAL  <= 1'b0;
        end else if (load_word) begin
            shift_ff   <= hold_ff >> 1;
            bit_cnt_ff <= ZERO5;
            active_ff  <= 1'b1;
            TX_SERIAL  <= hold_ff[0];
        end else if (last_bit) begin
            active_ff  <= 1'b0;
            bit_cnt_ff <= ZERO5;
            TX_SERIAL  <= 1'b0;
        end else if (active_ff) begin
            shift_ff   <= shift_ff >> 1;
            bit_cnt_ff <= bit_cnt_ff + ONE5;
            TX_SERIAL  <= shift_ff[0];
        end
    end

    assign pipe_idle = ctrl_ff[CTRL_PIPE] & ctrl_ff[CTRL_FORCE_IDLE];

    always_ff @(posedge CLK) begin
        if (RST) begin
            TX_IDLE      <= 1'b0;
            RX_DETECT_EN <= 1'b0;
        end else begin
            TX_IDLE      <= pipe_idle;
            RX_DETECT_EN <= RX_DETECT_REQ & pipe_idle & TX_IDLE;
        end
    end

    always_comb begin
        if (ctrl_ff[CTRL_FORCE_DATA]) begin
            lock_mode = SXC_MODE_DATA;
        end else if (ctrl_ff[CTRL_FORCE_REF]) begin
            lock_mode = SXC_MODE_REF;
        end else begin
            lock_mode = SXC_MODE_AUTO;
        end
    end

    always_comb begin
        nxt_cru = cru_ff;
        if (!ctrl_ff[CTRL_RX_USED]) begin
            nxt_cru = SXC_CRU_OFF;
        end else begin
            case (lock_mode)
                SXC_MODE_DATA: nxt_cru = SXC_CRU_DATA;
                SXC_MODE_REF:  nxt_cru = SXC_CRU_REF;
                default: begin
                    if (PLL_STAT.pll_locked && PLL_STAT.ppm_error <= ppm_thr_ff) begin
                        nxt_cru = SXC_CRU_DATA;
                    end else begin
                        nxt_cru = SXC_CRU_REF;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cru_ff      <= SXC_CRU_OFF;
            RX_PWRDN    <= 1'b1;
            DATA_LOCKED <= 1'b0;
            REF_LOCKED  <= 1'b0;
        end else begin
            cru_ff      <= nxt_cru;
            RX_PWRDN    <= ~ctrl_ff[CTRL_RX_USED];
            DATA_LOCKED <= (nxt_cru == SXC_CRU_DATA);
            REF_LOCKED  <= ctrl_ff[CTRL_RX_USED] & PLL_STAT.pll_locked;
        end
    end

    always_comb begin
        ev               = '0;
        ev[EV_WORD_DONE] = last_bit;
        ev[EV_UNDERRUN]  = last_bit & ~hold_vld_ff;
        ev[EV_DATA_LOCK] = (nxt_cru == SXC_CRU_DATA) & ~DATA_LOCKED;
        ev[EV_REF_LOCK]  = ctrl_ff[CTRL_RX_USED] & PLL_STAT.pll_locked & ~REF_LOCKED;
    end

    // Set wins over write-one clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            IRQ         <= 1'b0;
        end else begin
            if (wr_acc && PREADY && APB_REQ.paddr == OFS_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~APB_REQ.pwdata[EV_N-1:0]) | ev;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev;
            end
            if (wr_acc && PREADY && APB_REQ.paddr == OFS_IRQ_MASK) begin
                irq_mask_ff <= APB_REQ.pwdata[EV_N-1:0];
            end
            IRQ <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Assertions
    property p_lsb_first;
        @(posedge CLK) disable iff (RST)
        load_word |=> (TX_SERIAL == $past(hold_ff[0]));
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first bit not LSB");

    property p_idle;
        @(posedge CLK) disable iff (RST)
        ##1 (TX_IDLE == $past(ctrl_ff[CTRL_PIPE] & ctrl_ff[CTRL_FORCE_IDLE]));
    endproperty
    a_idle: assert property (p_idle) else $error("idle outside pipe rule");

    property p_detect;
        @(posedge CLK) disable iff (RST)
        RX_DETECT_EN |-> TX_IDLE;
    endproperty
    a_detect: assert property (p_detect) else $error("detect without idle");

    property p_pwrdn;
        @(posedge CLK) disable iff (RST)
        !ctrl_ff[CTRL_RX_USED] |=> (RX_PWRDN && !DATA_LOCKED);
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("unused rx not off");

    property p_force_data;
        @(posedge CLK) disable iff (RST)
        (ctrl_ff[CTRL_FORCE_DATA] && ctrl_ff[CTRL_RX_USED]) |=> DATA_LOCKED;
    endproperty
    a_force_data: assert property (p_force_data) else $error("data lock not forced");

    property p_auto_gate;
        @(posedge CLK) disable iff (RST)
        (lock_mode == SXC_MODE_AUTO && PLL_STAT.ppm_error > ppm_thr_ff) |=> !DATA_LOCKED;
    endproperty
    a_auto_gate: assert property (p_auto_gate) else $error("switched above ppm");

    property p_ref_lock;
        @(posedge CLK) disable iff (RST)
        (ctrl_ff[CTRL_RX_USED] && PLL_STAT.pll_locked) |=> REF_LOCKED;
    endproperty
    a_ref_lock: assert property (p_ref_lock) else $error("ref lock missed");

    property p_gapless;
        @(posedge CLK) disable iff (RST)
        (last_bit && hold_vld_ff) |=> active_ff && bit_cnt_ff == ZERO5;
    endproperty
    a_gapless: assert property (p_gapless) else $error("gap between words");

    property p_idle_off;
        @(posedge CLK) disable iff (RST)
        !ctrl_ff[CTRL_PIPE] |=> !TX_IDLE;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle without pipe mode");

    property p_force_ref;
        @(posedge CLK) disable iff (RST)
        (ctrl_ff[CTRL_RX_USED] && !ctrl_ff[CTRL_FORCE_DATA] && ctrl_ff[CTRL_FORCE_REF])
            |=> (cru_ff == SXC_CRU_REF && !DATA_LOCKED);
    endproperty
    a_force_ref: assert property (p_force_ref) else $error("ref lock not forced");

    // Checked on raw control bits so a broken mode decode still shows up
    property p_auto_lock;
        @(posedge CLK) disable iff (RST)
        (ctrl_ff[CTRL_RX_USED] && !ctrl_ff[CTRL_FORCE_DATA] && !ctrl_ff[CTRL_FORCE_REF]
            && PLL_STAT.pll_locked && PLL_STAT.ppm_error <= ppm_thr_ff) |=> DATA_LOCKED;
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("auto mode did not switch");

    property p_data_flag;
        @(posedge CLK) disable iff (RST)
        DATA_LOCKED == (cru_ff == SXC_CRU_DATA);
    endproperty
    a_data_flag: assert property (p_data_flag) else $error("data flag off state");

    c_gapless: cover property (@(posedge CLK) disable iff (RST) last_bit && hold_vld_ff);
    c_ref:     cover property (@(posedge CLK) disable iff (RST)
                               cru_ff == SXC_CRU_REF && ctrl_ff[CTRL_FORCE_REF]);
    c_word:   cover property (@(posedge CLK) disable iff (RST) load_word ##[1:20] load_word);
    c_detect: cover property (@(posedge CLK) disable iff (RST) RX_DETECT_EN);
    c_auto:   cover property (@(posedge CLK) disable iff (RST)
                              lock_mode == SXC_MODE_AUTO && DATA_LOCKED);

endmodule

// ---- src/sxc_pkg.sv ----
package sxc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STATUS   = 12'h004;
    localparam logic [11:0] OFS_TXWORD   = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_PPM_CFG  = 12'h014;

    // Control field positions
    localparam int CTRL_WIDTH_LO   = 0;
    localparam int CTRL_PIPE       = 2;
    localparam int CTRL_FORCE_IDLE = 3;
    localparam int CTRL_FORCE_DATA = 4;
    localparam int CTRL_FORCE_REF  = 5;
    localparam int CTRL_RX_USED    = 6;

    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [15:0] PPM_RESET     = 16'h0064;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Interrupt event bits
    localparam int EV_WORD_DONE = 0;
    localparam int EV_UNDERRUN  = 1;
    localparam int EV_DATA_LOCK = 2;
    localparam int EV_REF_LOCK  = 3;
    localparam int EV_N         = 4;

    localparam logic [4:0] ZERO5 = 5'h00;
    localparam logic [4:0] ONE5  = 5'h01;

    typedef enum logic [1:0] {
        SXC_W8  = 2'b00,
        SXC_W10 = 2'b01,
        SXC_W16 = 2'b10,
        SXC_W20 = 2'b11
    } sxc_width_t;

    typedef enum logic [1:0] {
        SXC_MODE_AUTO = 2'b00,
        SXC_MODE_REF  = 2'b01,
        SXC_MODE_DATA = 2'b10
    } sxc_lock_mode_t;

    typedef enum logic [1:0] {
        SXC_CRU_OFF  = 2'b00,
        SXC_CRU_REF  = 2'b01,
        SXC_CRU_DATA = 2'b10
    } sxc_cru_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sxc_apb_req_t;

    typedef struct packed {
        logic        pll_locked;
        logic [15:0] ppm_error;
    } sxc_pll_stat_t;

    function automatic logic [4:0] width_bits(input sxc_width_t w);
        case (w)
            SXC_W8:  width_bits = 5'h08;
            SXC_W10: width_bits = 5'h0A;
            SXC_W16: width_bits = 5'h10;
            default: width_bits = 5'h14;
        endcase
    endfunction

endpackage

// ---- test/sxc_rx_model.sv ----
module sxc_rx_model (
    input  wire logic        clk,
    input  wire logic        tx_serial,
    output logic [63:0]      hist_ff
);
    always_ff @(posedge clk) begin
        hist_ff <= {tx_serial, hist_ff[63:1]};
    end
endmodule

// ---- test/tb.sv ----
module tb import sxc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic          clk, rst, rx_det, pready, pslverr, tx_ser, tx_idle;
    logic          det_en, pwrdn, dlock, rlock, irq;
    logic [31:0]   prdata, rd;
    logic [63:0]   hist;
    sxc_apb_req_t  req;
    sxc_pll_stat_t pll;
    int            fail_count, checked;

    sxc_top DUT (.CLK(clk), .RST(rst), .APB_REQ(req), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .PLL_STAT(pll),
        .RX_DETECT_REQ(rx_det), .TX_SERIAL(tx_ser), .TX_IDLE(tx_idle),
        .RX_DETECT_EN(det_en), .RX_PWRDN(pwrdn), .DATA_LOCKED(dlock),
        .REF_LOCKED(rlock), .IRQ(irq));
    sxc_rx_model far_end (.clk(clk), .tx_serial(tx_ser), .hist_ff(hist));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        req <= '0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic found(input logic [19:0] v, input int w);
        logic m;
        m = 1'b0;
        for (int k = 0; k <= 64 - w; k++) begin
            if (((hist >> k) & ((64'h1 << w) - 64'h1)) === {44'h0, v}) m = 1'b1;
        end
        return m;
    endfunction

    task automatic t_regs();
        chk({pwrdn, dlock, tx_ser, irq}, 32'h8);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, OFS_PPM_CFG, 32'h0);
        chk(rd, {16'h0, PPM_RESET});
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, UNMAPPED_DATA);
        chk(pslverr, 1'b0);
    endtask

    task automatic t_serial();
        logic [19:0] wd [4];
        int          wb [4];
        // Words are not bit palindromes, so a reversed order cannot match
        wd = '{20'h00013, 20'h002A5, 20'h01234, 20'hA5A5B};
        wb = '{8, 10, 16, 20};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_CTRL, i);
            apb(1'b1, OFS_TXWORD, {12'h0, wd[i]});
            cyc(30);
            chk(found(wd[i], wb[i]), 1'b1);
        end
        // Two words queued at once must abut on the line
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_TXWORD, 32'h81);
        apb(1'b1, OFS_TXWORD, 32'hC3);
        cyc(30);
        chk(found(20'h0C381, 16), 1'b1);
    endtask

    task automatic t_idle();
        logic [7:0] c [3];
        c = '{8'h08, 8'h04, 8'h0C};
        @(posedge clk);
        rx_det <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_CTRL, {24'h0, c[i]});
            cyc(4);
            chk(tx_idle, i == 2);
            chk(det_en, i == 2);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h18);
        rx_det <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0);
        cyc(4);
        chk({tx_idle, det_en}, 32'h0);
    endtask

    task automatic t_lock();
        logic [7:0]  c [6];
        logic [15:0] p [6];
        logic [5:0]  lk, ex;
        c = '{8'h40, 8'h40, 8'h60, 8'h50, 8'h70, 8'h00};
        p = '{16'd100, 16'd101, 16'd100, 16'd101, 16'd101, 16'd100};
        lk = 6'b110111;
        ex = 6'b011001;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFS_CTRL, {24'h0, c[i]});
            pll <= '{pll_locked:lk[i], ppm_error:p[i]};
            cyc(6);
            chk(dlock, ex[i]);
            chk(pwrdn, !c[i][6]);
            if (c[i][6]) chk(rlock, lk[i]);
        end
    endtask

    task automatic t_irq();
        apb(1'b1, OFS_IRQ_MASK, 32'hF);
        apb(1'b1, OFS_CTRL, 32'h40);
        pll <= '{pll_locked:1'b1, ppm_error:16'd101};
        cyc(6);
        apb(1'b1, OFS_IRQ_STAT, 32'hF);
        pll <= '{pll_locked:1'b1, ppm_error:16'd100};
        cyc(6);
        chk(irq, 1'b1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rd[EV_DATA_LOCK], 1'b1);
        chk(rd, 32'h1 << EV_DATA_LOCK);
        apb(1'b1, OFS_IRQ_MASK, 32'hB);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'hF);
        cyc(2);
        chk(irq, 1'b1);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        cyc(2);
        chk(irq, 1'b0);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        pll = '{pll_locked:1'b1, ppm_error:16'd100};
        rx_det = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_serial();
        t_idle();
        t_lock();
        t_irq();
        complete_run();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
